/* dv/charger_dev_model.sv */
// behavioural charger register target on the two-wire bus
`timescale 1ns/100ps
module charger_dev_model (
    input wire logic scl_i,
    input wire logic sda_i,
    input wire logic slow_i,
    output logic scl_oe_o,
    output logic sda_oe_o
);
    import charger_link_pkg::*;
    byte_t regs[0:255];
    byte_t sh;
    byte_t ptr;
    int bc;
    int nb;
    logic act = 0;
    logic rd = 0;
    logic ok = 0;
    logic host_mode = 0; // default mode after power up
    initial begin
        scl_oe_o = 0;
        sda_oe_o = 0;
        for (int i = 0; i < 256; i++) regs[i] = 8'h5a ^ byte_t'(i);
    end
    always @(negedge sda_i) if (scl_i) begin
        act = 1;
        // the controller's first scl fall after a start carries no bit
        bc = -1;
        nb = 0;
        rd = 0;
    end
    always @(posedge sda_i) if (scl_i) act = 0;
    always @(posedge scl_i) if (act) begin
        if (bc < 8 && !(rd && nb > 0)) sh = {sh[6:0], sda_i};
        else if (bc == 8 && rd && nb > 0 && sda_i) ok = 0;
    end
    always @(negedge scl_i) if (act) begin
        if (bc == 7) begin
            sda_oe_o = 0;
            if (!(rd && nb > 0)) begin
                if (nb == 0) begin
                    rd = sh[0];
                    ok = sh[7:1] == TARGET_ADDR;
                end else if (nb == 1) begin
                    ptr = sh;
                    ok = sh <= 8'h48;
                end else begin
                    regs[ptr] = sh;
                    host_mode = 1;
                    ptr++;
                end
                sda_oe_o = ok;
            end
            // stretch the ack slot to exercise the controller's wait
            if (slow_i) begin
                scl_oe_o = 1;
                // long enough to outlast the controller's low phase at either rate
                #8000 scl_oe_o = 0;
            end
            bc = 8;
        end else if (bc == 8) begin
            bc = 0;
            nb++;
            sda_oe_o = 0;
            act = ok;
            if (ok && rd) begin
                sh = ptr > 8'h25 ? 8'hff : regs[ptr];
                ptr++;
                sda_oe_o = !sh[7];
            end
        end else begin
            bc++;
            if (rd && nb > 0) sda_oe_o = !sh[7 - bc];
        end
    end
endmodule

/* dv/charger_link_host_tb_top.sv */
// self-checking bench for the charger link host
`timescale 1ns/100ps
module charger_link_host_tb_top;
    import charger_link_pkg::*;
    logic clk = 0;
    logic rstn = 0;
    logic wr = 0;
    logic rd = 0;
    logic slow = 0;
    logic [7:0] addr = 8'h00;
    logic [31:0] wdata = 0;
    logic [31:0] rdata;
    logic [31:0] st;
    logic [31:0] v;
    logic hc, hd, mc, md, so, sdo;
    wire scl = !(hc | mc);
    wire sda = !(hd | md);
    int mismatches = 0;
    int total_checks = 0;
    charger_link_host #(.KEEPALIVE_CYCLES(2000)) dut_u (.ref_clk_i(clk), .resetn_i(rstn),
        .addr_i(addr), .wdata_i(wdata), .wr_i(wr), .rd_i(rd), .rdata_o(rdata), .scl_i(scl),
        .scl_o(so), .scl_oe_o(hc), .sda_i(sda), .sda_o(sdo), .sda_oe_o(hd));
    charger_dev_model dev_u (.scl_i(scl), .sda_i(sda), .slow_i(slow), .scl_oe_o(mc),
        .sda_oe_o(md));
    function automatic logic [31:0] pat(int i);
        return 32'(8'ha1 + 8'(19 * i));
    endfunction
    task automatic chk(input string n, input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("MISMATCH %s expected %h seen %h", n, exp, got);
        end
    endtask
    task automatic bw(input byte_t a, input logic [31:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1;
        @(posedge clk);
        wr <= 0;
    endtask
    task automatic br(input byte_t a, output logic [31:0] d);
        @(posedge clk);
        addr <= a;
        rd <= 1;
        @(posedge clk);
        rd <= 0;
        #1 d = rdata;
    endtask
    task automatic run(input byte_t p, input logic r, input int n);
        bw(CMD_ADDR, 32'(n - 1) << CMD_COUNT_LSB | 32'(r) << CMD_READ_BIT | 32'(p));
        st = 32'h1;
        for (int i = 0; i < 30000 && st[STAT_BUSY_BIT]; i++) br(STATUS_ADDR, st);
    endtask
    task automatic t_reset;
        chk("oe", {hc, hd}, 0);
        chk("lvl", {so, sdo}, 0);
        chk("dflt", 32'(dev_u.host_mode), 0);
        br(CTRL_ADDR, v);
        chk("ctrl", v, 0);
        br(8'h0c, v);
        chk("unmapped", v, 0);
        $display("t_reset over");
    endtask
    task automatic t_multi;
        bw(CTRL_ADDR, 32'h1);
        for (int i = 0; i < 4; i++) bw(DATA_BASE + 8'(4 * i), pat(i));
        run(8'h03, 0, 4);
        chk("wstat", st, 32'h8);
        for (int i = 0; i < 4; i++) chk("dev", 32'(dev_u.regs[3 + i]), pat(i));
        chk("host", 32'(dev_u.host_mode), 1);
        for (int i = 0; i < 4; i++) bw(DATA_BASE + 8'(4 * i), 0);
        run(8'h03, 1, 4);
        chk("rstat", st, 32'h8);
        for (int i = 0; i < 4; i++) begin
            br(DATA_BASE + 8'(4 * i), v);
            chk("rdata", v, pat(i));
        end
        $display("t_multi over");
    endtask
    task automatic t_nack;
        run(8'h50, 1, 1);
        chk("nack", st, 32'h2);
        run(8'h26, 1, 2);
        br(DATA_BASE + 8'h04, v);
        chk("ones", v, 32'hff);
        $display("t_nack over");
    endtask
    task automatic t_refuse;
        run(RESERVED_SLOT, 0, 1);
        chk("rsvd", st, 32'hc);
        run(CHARGER_IRQ_MASK_TWO, 0, 2);
        chk("span", st, 32'hc);
        bw(DATA_BASE, 32'h3c);
        bw(CMD_ADDR, 32'(CHARGER_CONTROL_TWO));
        // a second order while busy must be dropped
        run(CHARGER_CONTROL_THREE, 0, 1);
        chk("busy", st, 32'hc);
        chk("kept", 32'(dev_u.regs[8'h12]), 32'h48);
        chk("wrote", 32'(dev_u.regs[8'h11]), 32'h3c);
        $display("t_refuse over");
    endtask
    task automatic t_slow;
        slow = 1;
        bw(CTRL_ADDR, 0);
        bw(DATA_BASE, 32'h96);
        run(TIMER_CONTROL, 0, 1);
        chk("swr", st, 32'h8);
        bw(DATA_BASE, 0);
        run(TIMER_CONTROL, 1, 1);
        br(DATA_BASE, v);
        chk("srd", v, 32'h96);
        slow = 0;
        $display("t_slow over");
    endtask
    task automatic t_keep;
        bw(CTRL_ADDR, 32'h3);
        for (int i = 0; i < 9000 && dev_u.regs[8'h10] !== KICK_VALUE; i++) @(posedge clk);
        chk("kick", 32'(dev_u.regs[8'h10]), 32'(KICK_VALUE));
        br(STATUS_ADDR, v);
        chk("kflags", v & 32'he, 32'h8);
        $display("t_keep over");
    endtask
    task automatic stop_test;
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    initial begin
        forever #12.5 clk = ~clk;
    end
    initial begin
        #2000000;
        mismatches++;
        stop_test;
    end
    initial begin
        repeat (16) @(posedge clk);
        rstn <= 1;
        @(posedge clk);
        t_reset;
        t_multi;
        t_nack;
        t_refuse;
        t_slow;
        t_keep;
        stop_test;
    end
endmodule

/* hw/charger_link_host.sv */
// serial bus controller that reads and writes the charger register map
// Function
// - every byte is exactly eight bits
// - receiver gets an acknowledge slot per byte
// - bits go most significant first
// - target may stretch clock; controller waits
// - controller generates every clock pulse, ninth included
// - transmitter releases data; acknowledger holds low
// - high ninth bit is nack; stop follows
// - first byte is address plus direction bit
// - controller kicks watchdog before it expires
// - controller never writes reserved offsets
// - start, stop on data edge; data changes low
`timescale 1ns/100ps
module charger_link_host #(
    parameter int DEPTH = 8,
    parameter int KEEPALIVE_CYCLES = charger_link_pkg::KEEPALIVE_CYC,
    parameter charger_link_pkg::byte_t KICK_REG = charger_link_pkg::CHARGER_CONTROL_ONE,
    parameter charger_link_pkg::byte_t KICK_BYTE = charger_link_pkg::KICK_VALUE
) (
    input wire logic ref_clk_i,
    input wire logic resetn_i,
    input wire logic [7:0] addr_i,
    input wire logic [31:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [31:0] rdata_o,
    input wire logic scl_i,
    output logic scl_o,
    output logic scl_oe_o,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe_o
);
    import charger_link_pkg::*;

    localparam int IW = $clog2(DEPTH);
    localparam int KW = $clog2(KEEPALIVE_CYCLES + 1);

    bus_state_t state;
    phase_t phase;
    logic [1:0] q;
    logic [3:0] slot;
    byte_t shreg;
    byte_t pointer;
    byte_t buffer [DEPTH];
    byte_t next_tx;
    logic [IW-1:0] idx;
    logic [IW-1:0] last;
    logic rd_dir;
    logic kick_xfer;
    logic scl_drive;
    logic sda_drive;
    logic bit_low;
    logic tick;
    logic ctrl_fast;
    logic ctrl_keepalive;
    logic ack_err;
    logic refused;
    logic done;
    logic [KW-1:0] ka_cnt;
    logic ka_due;
    logic cmd_wr;
    logic cmd_ok;
    logic span_reserved;
    logic slot_end;
    logic nack_seen;
    logic write_acked;
    logic stop_end;
    logic [31:0] read_value;

    line_if line ();

    line_sync u_sync (
        .ref_clk_i(ref_clk_i),
        .resetn_i(resetn_i),
        .scl_i(scl_i),
        .sda_i(sda_i),
        .line(line.src)
    );

    // timer held while idle or while the target stretches the clock
    quarter_timer u_timer (
        .ref_clk_i(ref_clk_i),
        .resetn_i(resetn_i),
        .fast_i(ctrl_fast),
        .clear_i((state == ST_IDLE) || (q == 2'd2 && !line.scl)),
        .tick_o(tick)
    );

    function automatic logic is_reserved(input byte_t a);
        return (a == RESERVED_SLOT) || (a > CHARGER_IRQ_MASK_TWO);
    endfunction

    function automatic logic is_data(input byte_t a);
        return (a >= DATA_BASE) && (a < DATA_BASE + 8'(4 * DEPTH)) && (a[1:0] == 2'h0);
    endfunction

    function automatic logic [IW-1:0] data_index(input byte_t a);
        byte_t off;
        off = a - DATA_BASE;
        return off[IW+1:2];
    endfunction

    // a write span that touches a reserved offset is refused whole
    always_comb begin
        span_reserved = 1'b0;
        for (int i = 0; i < DEPTH; i++) begin
            if (i <= int'(wdata_i[CMD_COUNT_LSB +: IW]) &&
                is_reserved(wdata_i[CMD_POINTER_LSB +: 8] + 8'(i))) begin
                span_reserved = 1'b1;
            end
        end
    end

    assign cmd_wr = wr_i && (addr_i == CMD_ADDR);
    assign cmd_ok = cmd_wr && (state == ST_IDLE) && (wdata_i[CMD_READ_BIT] || !span_reserved);
    assign ka_due = ctrl_keepalive && (ka_cnt == KW'(KEEPALIVE_CYCLES));
    assign slot_end = tick && (state == ST_BITS) && (q == 2'd3) && (slot == BYTE_BITS);
    assign nack_seen = slot_end && (phase != PH_READ) && line.sda;
    assign write_acked = slot_end && (phase == PH_WRITE) && !line.sda;
    assign stop_end = tick && (state == ST_STOP) && (q == 2'd3);

    // open drain: only ever pull low
    assign scl_o = 1'b0;
    assign sda_o = 1'b0;
    assign scl_oe_o = scl_drive;
    assign sda_oe_o = sda_drive;

    always_comb begin
        if (slot == BYTE_BITS) begin
            bit_low = (phase == PH_READ) && (idx != last);
        end else begin
            bit_low = (phase != PH_READ) && !shreg[7];
        end
        if (kick_xfer) begin
            next_tx = KICK_BYTE;
        end else if (phase == PH_POINTER) begin
            next_tx = buffer[0];
        end else begin
            next_tx = buffer[idx + 1'b1];
        end
    end

    // bus sequencer, four quarters per bit
    always_ff @(posedge ref_clk_i) begin
        if (!resetn_i) begin
            state <= ST_IDLE;
            phase <= PH_ADDR_W;
            q <= 2'd0;
            slot <= 4'd0;
            shreg <= 8'h00;
            pointer <= 8'h00;
            idx <= '0;
            last <= '0;
            rd_dir <= 1'b0;
            kick_xfer <= 1'b0;
            scl_drive <= 1'b0;
            sda_drive <= 1'b0;
        end else if (state == ST_IDLE) begin
            q <= 2'd0;
            phase <= PH_ADDR_W;
            if (cmd_ok) begin
                state <= ST_START;
                pointer <= wdata_i[CMD_POINTER_LSB +: 8];
                rd_dir <= wdata_i[CMD_READ_BIT];
                last <= wdata_i[CMD_COUNT_LSB +: IW];
                kick_xfer <= 1'b0;
            end else if (ka_due) begin
                state <= ST_START;
                pointer <= KICK_REG;
                rd_dir <= 1'b0;
                last <= '0;
                kick_xfer <= 1'b1;
            end
        end else if (tick) begin
            q <= q + 2'd1;
            case (state)
                ST_START: begin
                    if (q == 2'd0) begin
                        sda_drive <= 1'b0;
                    end
                    if (q == 2'd1) begin
                        scl_drive <= 1'b0;
                    end
                    if (q == 2'd2) begin
                        sda_drive <= 1'b1;
                    end
                    if (q == 2'd3) begin
                        state <= ST_BITS;
                        scl_drive <= 1'b1;
                        slot <= 4'd0;
                        shreg <= {TARGET_ADDR, phase == PH_ADDR_R};
                    end
                end
                ST_BITS: begin
                    if (q == 2'd0) begin
                        sda_drive <= bit_low;
                    end
                    if (q == 2'd1) begin
                        scl_drive <= 1'b0;
                    end
                    if (q == 2'd3) begin
                        scl_drive <= 1'b1;
                        if (slot != BYTE_BITS) begin
                            shreg <= {shreg[6:0], line.sda};
                            slot <= slot + 4'd1;
                        end else begin
                            slot <= 4'd0;
                            if (phase == PH_READ) begin
                                idx <= idx + 1'b1;
                                if (idx == last) begin
                                    state <= ST_STOP;
                                end
                            end else if (line.sda) begin
                                state <= ST_STOP;
                            end else if (phase == PH_ADDR_W) begin
                                phase <= PH_POINTER;
                                shreg <= pointer;
                            end else if (phase == PH_POINTER && rd_dir) begin
                                state <= ST_START;
                                phase <= PH_ADDR_R;
                            end else if (phase == PH_POINTER) begin
                                phase <= PH_WRITE;
                                idx <= '0;
                                shreg <= next_tx;
                            end else if (phase == PH_ADDR_R) begin
                                phase <= PH_READ;
                                idx <= '0;
                            end else if (idx == last) begin
                                state <= ST_STOP;
                            end else begin
                                idx <= idx + 1'b1;
                                shreg <= next_tx;
                            end
                        end
                    end
                end
                ST_STOP: begin
                    if (q == 2'd0) begin
                        sda_drive <= 1'b1;
                    end
                    if (q == 2'd1) begin
                        scl_drive <= 1'b0;
                    end
                    if (q == 2'd2) begin
                        sda_drive <= 1'b0;
                    end
                    if (q == 2'd3) begin
                        state <= ST_IDLE;
                    end
                end
                default: begin
                    state <= ST_IDLE;
                end
            endcase
        end
    end

    // read bytes land in the buffer; software writes only while idle
    always_ff @(posedge ref_clk_i) begin
        if (slot_end && phase == PH_READ) begin
            buffer[idx] <= shreg;
        end else if (wr_i && state == ST_IDLE && is_data(addr_i)) begin
            buffer[data_index(addr_i)] <= wdata_i[7:0];
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (!resetn_i) begin
            ctrl_fast <= CTRL_FAST_RESET;
            ctrl_keepalive <= CTRL_KEEPALIVE_RESET;
        end else if (wr_i && addr_i == CTRL_ADDR) begin
            ctrl_fast <= wdata_i[CTRL_FAST_BIT];
            ctrl_keepalive <= wdata_i[CTRL_KEEPALIVE_BIT];
        end
    end

    // status flags clear only when a new command is taken
    always_ff @(posedge ref_clk_i) begin
        if (!resetn_i) begin
            ack_err <= 1'b0;
            refused <= 1'b0;
            done <= 1'b0;
        end else if (cmd_ok) begin
            ack_err <= 1'b0;
            refused <= 1'b0;
            done <= 1'b0;
        end else begin
            if (cmd_wr) begin
                refused <= 1'b1;
            end
            if (nack_seen) begin
                ack_err <= 1'b1;
            end
            if (stop_end && !kick_xfer) begin
                done <= !ack_err;
            end
        end
    end

    // every acked write restarts the device watchdog, so restart ours too
    always_ff @(posedge ref_clk_i) begin
        if (!resetn_i || !ctrl_keepalive || write_acked) begin
            ka_cnt <= '0;
        end else if (!ka_due) begin
            ka_cnt <= ka_cnt + 1'b1;
        end
    end

    always_comb begin
        read_value = 32'h0;
        if (addr_i == CTRL_ADDR) begin
            read_value[CTRL_FAST_BIT] = ctrl_fast;
            read_value[CTRL_KEEPALIVE_BIT] = ctrl_keepalive;
        end else if (addr_i == STATUS_ADDR) begin
            read_value[STAT_BUSY_BIT] = (state != ST_IDLE);
            read_value[STAT_ACK_ERR_BIT] = ack_err;
            read_value[STAT_REFUSED_BIT] = refused;
            read_value[STAT_DONE_BIT] = done;
        end else if (is_data(addr_i)) begin
            read_value[7:0] = buffer[data_index(addr_i)];
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (!resetn_i || !rd_i) begin
            rdata_o <= 32'h0;
        end else begin
            rdata_o <= read_value;
        end
    end

    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!resetn_i);

    logic bits_high;
    assign bits_high = (state == ST_BITS) && !scl_drive;

    property p_byte_len;
        (state == ST_BITS) |-> (slot <= BYTE_BITS);
    endproperty
    a_byte_len: assert property (p_byte_len) else $error("slot beyond nine");

    property p_ack_release;
        (state == ST_BITS && slot == BYTE_BITS && phase != PH_READ && q != 2'd0) |-> !sda_drive;
    endproperty
    a_ack_release: assert property (p_ack_release) else $error("data held in ack");

    property p_msb_first;
        (tick && state == ST_BITS && q == 2'd0 && slot != BYTE_BITS && phase != PH_READ)
            |=> (sda_drive != $past(shreg[7]));
    endproperty
    a_msb_first: assert property (p_msb_first) else $error("wrong bit driven");

    property p_stretch;
        (state != ST_IDLE && q == 2'd2 && !line.scl) |=> (q == 2'd2);
    endproperty
    a_stretch: assert property (p_stretch) else $error("stretch ignored");

    property p_addr_byte;
        (state == ST_BITS && $past(state) == ST_START) |-> (shreg[7:1] == TARGET_ADDR);
    endproperty
    a_addr_byte: assert property (p_addr_byte) else $error("bad address byte");

    property p_nack_stop;
        nack_seen |=> (state == ST_STOP && ack_err);
    endproperty
    a_nack_stop: assert property (p_nack_stop) else $error("nack not stopped");

    property p_data_stable;
        (bits_high && $past(bits_high)) |-> $stable(sda_drive);
    endproperty
    a_data_stable: assert property (p_data_stable) else $error("data moved, clock high");

    property p_start_edge;
        (tick && state == ST_START && q == 2'd2) |-> (line.scl && !scl_drive) ##1 sda_drive;
    endproperty
    a_start_edge: assert property (p_start_edge) else $error("bad start");

    property p_refuse;
        (cmd_wr && state == ST_IDLE && !wdata_i[CMD_READ_BIT] && span_reserved)
            |=> (state == ST_IDLE && refused);
    endproperty
    a_refuse: assert property (p_refuse) else $error("reserved write sent");

    property p_kick;
        (ka_due && state == ST_IDLE && !cmd_ok) |=> (state == ST_START && kick_xfer);
    endproperty
    a_kick: assert property (p_kick) else $error("keepalive missed");

    c_read_done: cover property (slot_end && phase == PH_READ && idx == last);
    c_write_done: cover property (stop_end && !ack_err && !kick_xfer);
    c_nack: cover property (nack_seen);
    c_stretch: cover property (state == ST_BITS && q == 2'd2 && !line.scl);
endmodule

/* hw/line_sync.sv */
// two-stage synchronisers for the serial clock and data pins
`timescale 1ns/100ps
module line_sync (
    input wire logic ref_clk_i,
    input wire logic resetn_i,
    input wire logic scl_i,
    input wire logic sda_i,
    line_if.src line
);
    logic [1:0] scl_meta;
    logic [1:0] sda_meta;

    // idle bus reads high, so reset to high avoids a false start
    always_ff @(posedge ref_clk_i) begin
        if (!resetn_i) begin
            scl_meta <= 2'h3;
            sda_meta <= 2'h3;
        end else begin
            scl_meta <= {scl_meta[0], scl_i};
            sda_meta <= {sda_meta[0], sda_i};
        end
    end

    assign line.scl = scl_meta[1];
    assign line.sda = sda_meta[1];
endmodule

/* hw/quarter_timer.sv */
// quarter bit period tick generator for the serial clock
`timescale 1ns/100ps
module quarter_timer #(
    parameter int FAST_CYC = charger_link_pkg::FAST_QUARTER_CYC,
    parameter int STD_CYC = charger_link_pkg::STD_QUARTER_CYC
) (
    input wire logic ref_clk_i,
    input wire logic resetn_i,
    input wire logic fast_i,
    input wire logic clear_i,
    output logic tick_o
);
    localparam int W = $clog2(STD_CYC + 1);
    logic [W-1:0] cnt;

    always_ff @(posedge ref_clk_i) begin
        if (!resetn_i || clear_i || tick_o) begin
            cnt <= '0;
        end else begin
            cnt <= cnt + 1'b1;
        end
    end

    assign tick_o = (cnt == (fast_i ? W'(FAST_CYC - 1) : W'(STD_CYC - 1)));
endmodule

/* pkg/charger_link_pkg.sv */
// constants shared by the charger link host modules
package charger_link_pkg;
    typedef logic [7:0] byte_t;
    typedef enum logic [1:0] {ST_IDLE, ST_START, ST_BITS, ST_STOP} bus_state_t;
    typedef enum logic [2:0] {PH_ADDR_W, PH_POINTER, PH_WRITE, PH_ADDR_R, PH_READ} phase_t;

    localparam logic [6:0] TARGET_ADDR = 7'h6b;
    localparam logic [3:0] BYTE_BITS = 4'h8;

    // device register map
    localparam byte_t MINIMUM_SYSTEM_VOLTAGE = 8'h00;
    localparam byte_t CHARGE_VOLTAGE_LIMIT = 8'h01;
    localparam byte_t CHARGE_CURRENT_LIMIT = 8'h03;
    localparam byte_t INPUT_VOLTAGE_LIMIT = 8'h05;
    localparam byte_t INPUT_CURRENT_LIMIT = 8'h06;
    localparam byte_t PRECHARGE_CONTROL = 8'h08;
    localparam byte_t TERMINATION_CONTROL = 8'h09;
    localparam byte_t RECHARGE_CONTROL = 8'h0a;
    localparam byte_t OTG_VOLTAGE_SETTING = 8'h0b;
    localparam byte_t OTG_CURRENT_SETTING = 8'h0d;
    localparam byte_t TIMER_CONTROL = 8'h0e;
    localparam byte_t CHARGER_CONTROL_ZERO = 8'h0f;
    localparam byte_t CHARGER_CONTROL_ONE = 8'h10;
    localparam byte_t CHARGER_CONTROL_TWO = 8'h11;
    localparam byte_t CHARGER_CONTROL_THREE = 8'h12;
    localparam byte_t CHARGER_CONTROL_FOUR = 8'h13;
    localparam byte_t CHARGER_CONTROL_FIVE = 8'h14;
    localparam byte_t RESERVED_SLOT = 8'h15;
    localparam byte_t TEMPERATURE_CONTROL = 8'h16;
    localparam byte_t THERMISTOR_CONTROL_ZERO = 8'h17;
    localparam byte_t THERMISTOR_CONTROL_ONE = 8'h18;
    localparam byte_t OPTIMIZED_INPUT_CURRENT = 8'h19;
    localparam byte_t CHARGER_STATUS_ZERO = 8'h1b;
    localparam byte_t CHARGER_STATUS_ONE = 8'h1c;
    localparam byte_t CHARGER_STATUS_TWO = 8'h1d;
    localparam byte_t CHARGER_STATUS_THREE = 8'h1e;
    localparam byte_t CHARGER_STATUS_FOUR = 8'h1f;
    localparam byte_t FAULT_STATUS_ZERO = 8'h20;
    localparam byte_t FAULT_STATUS_ONE = 8'h21;
    localparam byte_t CHARGER_EVENT_ZERO = 8'h22;
    localparam byte_t CHARGER_EVENT_ONE = 8'h23;
    localparam byte_t CHARGER_EVENT_TWO = 8'h24;
    localparam byte_t CHARGER_EVENT_THREE = 8'h25;
    localparam byte_t FAULT_EVENT_ZERO = 8'h26;
    localparam byte_t FAULT_EVENT_ONE = 8'h27;
    localparam byte_t CHARGER_IRQ_MASK_ZERO = 8'h28;
    localparam byte_t CHARGER_IRQ_MASK_ONE = 8'h29;
    localparam byte_t CHARGER_IRQ_MASK_TWO = 8'h2a;

    // timing
    localparam int CLK_PERIOD_NS = 25;
    localparam int FAST_BIT_NS = 2500;
    localparam int STD_BIT_NS = 10000;
    localparam int FAST_QUARTER_CYC = (FAST_BIT_NS + 4 * CLK_PERIOD_NS - 1) / (4 * CLK_PERIOD_NS);
    localparam int STD_QUARTER_CYC = (STD_BIT_NS + 4 * CLK_PERIOD_NS - 1) / (4 * CLK_PERIOD_NS);
    localparam int KEEPALIVE_US = 10000;
    localparam int KEEPALIVE_CYC = KEEPALIVE_US * 1000 / CLK_PERIOD_NS;
    localparam byte_t KICK_VALUE = 8'h08;

    // own register port map
    localparam byte_t CTRL_ADDR = 8'h00;
    localparam byte_t CMD_ADDR = 8'h04;
    localparam byte_t STATUS_ADDR = 8'h08;
    localparam byte_t DATA_BASE = 8'h10;
    localparam int CTRL_FAST_BIT = 0;
    localparam int CTRL_KEEPALIVE_BIT = 1;
    localparam int CMD_POINTER_LSB = 0;
    localparam int CMD_READ_BIT = 8;
    localparam int CMD_COUNT_LSB = 12;
    localparam int STAT_BUSY_BIT = 0;
    localparam int STAT_ACK_ERR_BIT = 1;
    localparam int STAT_REFUSED_BIT = 2;
    localparam int STAT_DONE_BIT = 3;
    localparam logic CTRL_FAST_RESET = 1'b0;
    localparam logic CTRL_KEEPALIVE_RESET = 1'b0;
endpackage

/* pkg/line_if.sv */
// synchronised bus line levels passed between host modules
`timescale 1ns/100ps
interface line_if;
    logic scl;
    logic sda;
    modport src (output scl, output sda);
    modport dst (input scl, input sda);
endinterface
